// >>> debugger_probe.sv
// Purpose: debugger probe model driving the port in monitor mode
// Assumes: 500 ns probe clock per sent nibble, 400 ns per read nibble, standing high between frames
// Notes: shared pins resolved from the port's enables, probe drives otherwise
module debugger_probe (
    input wire logic ck_out,
    input wire logic ck_oe,
    input wire logic fs_out,
    input wire logic fs_oe,
    input wire logic [3:0] nb_out,
    input wire logic nb_oe,
    output logic ck_w,
    output logic fs_w,
    output logic [3:0] nb_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pck = 1'b1;
    logic pfs = 1'b1;
    logic [3:0] pnb = 4'h0;
    logic [3:0] x;
    assign ck_w = ck_oe ? ck_out : pck;
    assign fs_w = fs_oe ? fs_out : pfs;
    assign nb_w = nb_oe ? nb_out : pnb;
    // one probe clock, nibble taken before the rising edge
    task automatic get(output logic [3:0] n);
        pck = 1'b0;
        #200;
        n = nb_w;
        pck = 1'b1;
        #200;
    endtask
    // nibble and sync settle before the clock
    task automatic put(input logic [3:0] n, input logic s);
        pnb = n;
        pfs = s;
        #100;
        get(x);
    endtask
    // noise nibble, command, address, write data
    task automatic frame(input logic [3:0] c, input logic [31:0] a, d,
        input int dn);
        // keep probe edges off the hclk edges
        #10;
        put(4'hF, 1'b1);
        put(c, 1'b0);
        for (int i = 0; i < 8; i++) put(a[4*i+:4], 1'b0);
        for (int i = 0; i < dn; i++) put(d[4*i+:4], 1'b0);
        pnb = ~pnb;
    endtask
endmodule

// >>> trace_and_ram_monitor_port_tb_top.sv
// Purpose: self-checking bench for the trace and ram monitor port
// Assumes: 50 ns hclk, probe clock of 500 ns per sent nibble and 400 ns per read nibble in monitor mode
// Notes: bus responder acks one cycle after each request
module trace_and_ram_monitor_port_tb_top import trace_monitor_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic port_reset_n = 1'b0;
    logic port_mode_select = 1'b0;
    logic branch_taken = 1'b0;
    logic [31:0] branch_target = 32'h0000_0000;
    logic mon_ack = 1'b0;
    logic mon_err = 1'b0;
    logic [31:0] mon_rdata = 32'h0000_0000;
    logic hreadyout, ck_o, ck_oe, fs_o, fs_oe, nb_oe, ck_w, fs_w, c;
    logic mon_req, mon_write, lwr;
    logic [1:0] mon_size, lsz;
    logic [3:0] nb_o, nb_w;
    logic [31:0] hrdata, mon_addr, mon_wdata, la, lwd, rd;
    int bad_count = 0, tests_run = 0, cyc = 0, acks = 0, k = 0;
    trace_monitor_port dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(), .port_reset_n(port_reset_n),
        .port_mode_select(port_mode_select), .debug_port_clock_in(ck_w),
        .debug_port_clock_out(ck_o), .debug_port_clock_oe(ck_oe),
        .frame_sync_n_in(fs_w), .frame_sync_n_out(fs_o),
        .frame_sync_n_oe(fs_oe), .debug_nibble_bus_in(nb_w),
        .debug_nibble_bus_out(nb_o), .debug_nibble_bus_oe(nb_oe),
        .branch_taken(branch_taken), .branch_target(branch_target),
        .mon_req(mon_req), .mon_write(mon_write), .mon_size(mon_size),
        .mon_addr(mon_addr), .mon_wdata(mon_wdata), .mon_ack(mon_ack),
        .mon_rdata(mon_rdata), .mon_err(mon_err)
    );
    debugger_probe probe (
        .ck_out(ck_o), .ck_oe(ck_oe), .fs_out(fs_o), .fs_oe(fs_oe),
        .nb_out(nb_o), .nb_oe(nb_oe), .ck_w(ck_w), .fs_w(fs_w), .nb_w(nb_w)
    );
    initial forever #25 hclk = ~hclk;
    // system bus responder, error on one chosen address
    always @(posedge hclk) begin
        mon_ack <= 1'b0;
        mon_err <= 1'b0;
        if (mon_req && !mon_ack) begin
            mon_ack <= 1'b1;
            mon_err <= (mon_addr == 32'hFFFF_E100);
            mon_rdata <= (mon_size == SIZE_BYTE) ? 32'hA5A5_A5A5
                : 32'h1234_5678;
            la <= mon_addr;
            lwr <= mon_write;
            lsz <= mon_size;
            lwd <= mon_wdata;
            acks <= acks + 1;
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [63:0] s, e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic step();
        @(posedge hclk);
        #1;
        k++;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, wd,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic rchk(input logic [7:0] o, input logic [31:0] e);
        ahb(1'b0, {24'h00_0000, o}, 32'h0000_0000, rd);
        chk("register", rd, e);
    endtask
    task automatic wctl(input logic [31:0] v);
        ahb(1'b1, {24'h00_0000, OFS_CTRL}, v, rd);
    endtask
    task automatic preset(input logic m);
        @(posedge hclk);
        port_reset_n <= 1'b0;
        port_mode_select <= m;
        repeat (6) step();
        if (!m) chk("reset pins", {nb_oe, nb_w}, {1'b1, 4'hF});
        @(posedge hclk);
        port_reset_n <= 1'b1;
        repeat (6) step();
        ahb(1'b0, {24'h00_0000, OFS_STATUS}, 32'h0000_0000, rd);
        chk("mode", rd[0], m);
    endtask
    task automatic trace(input logic [31:0] a, input logic [3:0] h,
        input int n, m);
        @(posedge hclk);
        branch_target <= a;
        branch_taken <= 1'b1;
        @(posedge hclk);
        branch_taken <= 1'b0;
        k = 0;
        step();
        while (!(fs_w === 1'b1 && nb_w[3:2] === 2'b10) && k < 12) step();
        chk("latency", k == 2 || k == 3, 1'b1);
        chk("header", nb_w, h);
        while (fs_w !== 1'b0 && k < 20) step();
        for (int i = 0; i < m; i++) begin
            chk("nibble", {fs_w, nb_w}, {1'b0, a[4*i+:4]});
            c = ck_w;
            step();
            chk("clock", ck_w ^ c, 1'b1);
            step();
        end
        if (m == n) chk("idle", {fs_w, nb_w}, {1'b1, NIB_IDLE});
    endtask
    task automatic mon(input logic [3:0] cm, input logic [31:0] a, d,
        input int dn, input logic [3:0] st, input int rn, ac,
        input logic [31:0] er);
        int n0;
        logic [3:0] v;
        n0 = acks;
        rd = 32'h0000_0000;
        probe.frame(cm, a, d, dn);
        step();
        if (ac > 0) chk("busy", {nb_oe, nb_w}, {1'b1, 4'h0});
        k = 0;
        while (nb_w !== st && k < 60) step();
        chk("status", {nb_oe, nb_w}, {1'b1, st});
        probe.pfs = 1'b1;
        repeat (4) step();
        for (int i = 0; i < rn; i++) begin
            probe.get(v);
            rd[4*i+:4] = v;
        end
        probe.get(v);
        chk("read data", rd, er);
        chk("released", nb_oe, 1'b0);
        chk("accesses", acks - n0, ac);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(OFS_CTRL, 32'h0000_0000);
        wctl(32'h0000_0001);
        rchk(OFS_CTRL, 32'h0000_0001);
        rchk(8'h40, 32'h0000_0000);
        wctl(32'h0000_0000);
        preset(1'b0);
        rchk(OFS_LAST, 32'h0000_0000);
        trace(32'h0000_0005, 4'h8, 1, 1);
        trace(32'h1234_5678, 4'hB, 8, 8);
        trace(32'h1234_56A8, 4'h9, 2, 2);
        trace(32'h1234_A008, 4'hA, 4, 4);
        trace(32'hFFFF_FFF0, 4'hB, 8, 2);
        trace(32'h1234_A00C, 4'h8, 1, 1);
        rchk(OFS_LAST, 32'h1234_A00C);
        preset(1'b1);
        mon(4'hA, 32'hFFFF_E000, 0, 0, 4'h1, 8, 1, 32'h1234_5678);
        chk("read access", {lwr, lsz, la}, {1'b0, SIZE_LONG, 32'hFFFF_E000});
        mon(4'hE, 32'hFFFF_E004, 32'h89AB_CDEF, 8, 4'h1, 0, 1, 0);
        chk("write access", {lwr, lsz, lwd}, {1'b1, SIZE_LONG, 32'h89AB_CDEF});
        mon(4'h8, 32'hFFFF_E003, 0, 0, 4'h1, 2, 1, 32'h0000_00A5);
        mon(4'hB, 32'hFFFF_E000, 0, 0, 4'h3, 0, 0, 0);
        mon(4'h9, 32'hFFFF_E001, 0, 0, 4'h5, 0, 0, 0);
        mon(4'hD, 32'hFFFF_E003, 32'h0000_1234, 4, 4'h5, 0, 0, 0);
        mon(4'hA, 32'hFFFF_E002, 0, 0, 4'h5, 0, 0, 0);
        mon(4'hA, 32'hFFFF_8000, 0, 0, 4'h5, 0, 0, 0);
        mon(4'hA, 32'hFFFF_E100, 0, 0, 4'h5, 0, 1, 0);
        wctl(32'h0000_0001);
        mon(4'h8, 32'h0000_1000, 0, 0, 4'h5, 0, 0, 0);
        wctl(32'h0000_0000);
        mon(4'h8, 32'h0000_1000, 0, 0, 4'h1, 2, 1, 32'h0000_00A5);
        end_sim();
    end
endmodule

// >>> trace_monitor_pkg.sv
// Purpose: shared constants and types for the trace and ram monitor port
// Assumes: hclk at 20 MHz, debug clock out at half that rate
// Notes: ahb register offsets are byte addresses of aligned words
package trace_monitor_pkg;
    // debug clock is hclk divided by two
    localparam int DCK_DIV = 2;
    // least branch-to-header latency in half debug clocks (1.5 clocks)
    localparam int LAT_MIN_HALF_DCK = 3;
    localparam int LAT_MIN_CYC = (LAT_MIN_HALF_DCK * DCK_DIV + 1) / 2;
    localparam logic [1:0] WAIT_INIT = 2'(LAT_MIN_CYC - 2);
    // register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h08;
    localparam int CTRL_SINGLE_CHIP = 0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // trace nibbles
    localparam logic [31:0] CMP_RESET = 32'h0000_0000;
    localparam logic [3:0] NIB_IDLE = 4'h3;
    localparam logic [3:0] NIB_RESET_LEVEL = 4'hF;
    localparam logic [1:0] HEAD_PREFIX = 2'h2;
    localparam logic [1:0] LEN_4 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] LEN_16 = 2'h2;
    localparam logic [1:0] LEN_32 = 2'h3;
    localparam logic [3:0] NIBS_4 = 4'h1;
    localparam logic [3:0] NIBS_8 = 4'h2;
    localparam logic [3:0] NIBS_16 = 4'h4;
    localparam logic [3:0] NIBS_32 = 4'h8;
    // monitor status nibble
    localparam logic [3:0] STAT_NOT_READY = 4'h0;
    localparam logic [3:0] STAT_READY = 4'h1;
    localparam logic [3:0] STAT_CMD_ERR = 4'h2;
    localparam logic [3:0] STAT_BUS_ERR = 4'h4;
    // monitor command nibble: valid, write, size
    localparam int CMD_VALID_BIT = 3;
    localparam int CMD_WRITE_BIT = 2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [3:0] ADDR_NIBS = 4'h8;
    // address areas
    localparam logic [31:0] IO8_BASE = 32'hFFFF_8000;
    localparam logic [31:0] IO8_MASK = 32'hFFFF_C000;
    localparam logic [31:0] INT_AREA_BASE = 32'hFFFF_0000;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_WAIT = 2'b01,
        T_SEND = 2'b10
    } trace_state_type;

    typedef enum logic [2:0] {
        M_CMD = 3'b000,
        M_ADDR = 3'b001,
        M_DATA = 3'b010,
        M_EXEC = 3'b011,
        M_READY = 3'b100,
        M_OUT = 3'b101
    } mon_state_type;

    typedef struct packed {
        logic rst_s1, rst_s2, mode_s1, mode_s2;
        logic ck_s1, ck_s2, ck_s3, fs_s1, fs_s2;
        logic [3:0] nb_s1, nb_s2;
        logic mode_mon, single_chip;
        trace_state_type tst;
        logic [1:0] wait_cnt;
        logic [3:0] tnib_left;
        logic [31:0] taddr, pend_addr, cmp;
        logic ck_o, ck_oe, fs_o, fs_oe, nb_oe;
        logic [3:0] nb_o;
        mon_state_type mst;
        logic [3:0] mcmd, mcnt, mstat;
        logic [31:0] maddr, mdata;
        logic mreq, hreadyout, wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
    } port_state_type;
endpackage

// >>> trace_monitor_port.sv
// Purpose: branch trace streamer and ram monitor behind a four bit debug port
// Assumes: pins are sampled through two flops; ahb-lite register slave
// Notes: all state lives in one struct, registered in one process
// Operation
// - trace mode drives debug clock at half rate
// - sync low only while address nibbles valid
// - address nibbles go least significant first
// - idle pattern 0011 when nothing to send
// - one header nibble 10xx before each address
// - codes 00 and 01 send one, two nibbles
// - codes 10 and 11 send four, eight nibbles
// - comparison address starts at zero
// - after last nibble sync high, idle pattern
// - new branch abandons transfer, no compare update
// - header 1.5 or 2 debug clocks after branch
// - instruction and exception branches traced alike
// - mode low at reset release selects trace
// - mode high at reset release selects monitor
// - monitor input captured only while sync low
// - address only reads, address plus data writes
// - status 0000 while busy, 0001 when done
// - read data follows once debugger raises sync
// - unknown command: no access, status bit 1
// - bus error: abandon, status bit 2
// - misaligned, io8 long, external single-chip are errors
// - mode select changes only during port reset
// - port reset clears port state except the address, data, command and count registers
module trace_monitor_port
    import trace_monitor_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic port_reset_n,
    input wire logic port_mode_select,
    input wire logic debug_port_clock_in,
    output logic debug_port_clock_out,
    output logic debug_port_clock_oe,
    input wire logic frame_sync_n_in,
    output logic frame_sync_n_out,
    output logic frame_sync_n_oe,
    input wire logic [3:0] debug_nibble_bus_in,
    output logic [3:0] debug_nibble_bus_out,
    output logic debug_nibble_bus_oe,
    input wire logic branch_taken,
    input wire logic [31:0] branch_target,
    output logic mon_req,
    output logic mon_write,
    output logic [1:0] mon_size,
    output logic [31:0] mon_addr,
    output logic [31:0] mon_wdata,
    input wire logic mon_ack,
    input wire logic [31:0] mon_rdata,
    input wire logic mon_err
);
    port_state_type s;
    port_state_type n;
    logic run_trace, slot, ck_rise, ck_fall, take, is_wr, cmd_ok, bus_err;
    logic ahb_acc, trace_hdr;
    logic [1:0] size, len_code;
    logic [3:0] len_nibs, data_nibs;

    assign run_trace = s.rst_s2 && !s.mode_mon;
    assign slot = s.ck_o;
    assign ck_rise = s.ck_s2 && !s.ck_s3;
    assign ck_fall = !s.ck_s2 && s.ck_s3;
    assign take = ck_rise && !s.fs_s2;
    assign size = s.mcmd[1:0];
    assign is_wr = s.mcmd[CMD_WRITE_BIT];
    assign cmd_ok = s.mcmd[CMD_VALID_BIT] && size != 2'h3;
    assign data_nibs = NIBS_8 << size;
    assign bus_err = (size == SIZE_WORD && s.maddr[0])
        || (size == SIZE_LONG && s.maddr[1:0] != 2'h0)
        || (size == SIZE_LONG && (s.maddr & IO8_MASK) == IO8_BASE)
        || (s.single_chip && s.maddr < INT_AREA_BASE);
    assign ahb_acc = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
    assign trace_hdr = run_trace && s.fs_o && s.nb_o[3:2] == HEAD_PREFIX;

    // length code from the last fully sent address
    always_comb begin
        if (s.pend_addr[31:4] == s.cmp[31:4]) begin
            len_code = LEN_4;
            len_nibs = NIBS_4;
        end else if (s.pend_addr[31:8] == s.cmp[31:8]) begin
            len_code = LEN_8;
            len_nibs = NIBS_8;
        end else if (s.pend_addr[31:16] == s.cmp[31:16]) begin
            len_code = LEN_16;
            len_nibs = NIBS_16;
        end else begin
            len_code = LEN_32;
            len_nibs = NIBS_32;
        end
    end

    always_comb begin
        n = s;
        n.rst_s1 = port_reset_n;
        n.rst_s2 = s.rst_s1;
        n.mode_s1 = port_mode_select;
        n.mode_s2 = s.mode_s1;
        n.ck_s1 = debug_port_clock_in;
        n.ck_s2 = s.ck_s1;
        n.ck_s3 = s.ck_s2;
        n.fs_s1 = frame_sync_n_in;
        n.fs_s2 = s.fs_s1;
        n.nb_s1 = debug_nibble_bus_in;
        n.nb_s2 = s.nb_s1;
        // ahb-lite slave, zero wait states
        n.hreadyout = 1'b1;
        n.wr_pend = ahb_acc && hwrite;
        n.wr_addr = haddr[7:0];
        if (s.wr_pend && s.wr_addr == OFS_CTRL) begin
            n.single_chip = hwdata[CTRL_SINGLE_CHIP];
        end
        if (ahb_acc && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL: n.hrdata = {31'h0000_0000, s.single_chip};
                OFS_STATUS: n.hrdata = {17'h0_0000, s.mstat, s.mst, s.tst,
                    s.tnib_left, s.rst_s2, s.mode_mon};
                OFS_LAST: n.hrdata = s.cmp;
                default: n.hrdata = 32'h0000_0000;
            endcase
        end
        if (!s.rst_s2) begin
            // port held in reset: catch mode, clear state machines, compare and pins
            n.mode_mon = s.mode_s2;
            n.tst = T_IDLE;
            n.wait_cnt = 2'h0;
            n.tnib_left = 4'h0;
            n.cmp = CMP_RESET;
            n.mst = M_CMD;
            n.mreq = 1'b0;
            n.mstat = STAT_NOT_READY;
            n.ck_o = 1'b1;
            n.fs_o = 1'b1;
            n.nb_o = NIB_RESET_LEVEL;
            n.ck_oe = !s.mode_s2;
            n.fs_oe = !s.mode_s2;
            n.nb_oe = !s.mode_s2;
        end else if (!s.mode_mon) begin
            n.ck_oe = 1'b1;
            n.fs_oe = 1'b1;
            n.nb_oe = 1'b1;
            n.ck_o = !s.ck_o;
            if (branch_taken) begin
                // any branch source, newest wins
                n.pend_addr = branch_target;
                n.tst = T_WAIT;
                n.wait_cnt = WAIT_INIT;
                n.fs_o = 1'b1;
                n.nb_o = NIB_IDLE;
            end else begin
                case (s.tst)
                    T_WAIT: begin
                        if (s.wait_cnt != 2'h0) begin
                            n.wait_cnt = s.wait_cnt - 2'h1;
                        end else if (slot) begin
                            n.fs_o = 1'b1;
                            n.nb_o = {HEAD_PREFIX, len_code};
                            n.taddr = s.pend_addr;
                            n.tnib_left = len_nibs;
                            n.tst = T_SEND;
                        end
                    end
                    T_SEND: begin
                        if (slot && s.tnib_left != 4'h0) begin
                            n.fs_o = 1'b0;
                            n.nb_o = s.taddr[3:0];
                            n.taddr = {4'h0, s.taddr[31:4]};
                            n.tnib_left = s.tnib_left - 4'h1;
                        end else if (slot) begin
                            n.fs_o = 1'b1;
                            n.nb_o = NIB_IDLE;
                            n.cmp = s.pend_addr;
                            n.tst = T_IDLE;
                        end
                    end
                    T_IDLE: begin
                        n.fs_o = 1'b1;
                        n.nb_o = NIB_IDLE;
                    end
                    default: n.tst = T_IDLE;
                endcase
            end
        end else begin
            n.ck_oe = 1'b0;
            n.fs_oe = 1'b0;
            case (s.mst)
                M_CMD: begin
                    n.nb_oe = 1'b0;
                    if (take) begin
                        n.mcmd = s.nb_s2;
                        n.mcnt = 4'h0;
                        n.maddr = 32'h0000_0000;
                        n.mdata = 32'h0000_0000;
                        n.mst = M_ADDR;
                    end
                end
                M_ADDR: begin
                    if (take) begin
                        n.maddr[s.mcnt[2:0]*4 +: 4] = s.nb_s2;
                        n.mcnt = s.mcnt + 4'h1;
                        if (s.mcnt == ADDR_NIBS - 4'h1) begin
                            n.mcnt = 4'h0;
                            n.mst = (is_wr && cmd_ok) ? M_DATA : M_EXEC;
                        end
                    end
                end
                M_DATA: begin
                    if (take) begin
                        n.mdata[s.mcnt[2:0]*4 +: 4] = s.nb_s2;
                        n.mcnt = s.mcnt + 4'h1;
                        if (s.mcnt == data_nibs - 4'h1) begin
                            n.mst = M_EXEC;
                        end
                    end
                end
                M_EXEC: begin
                    n.nb_oe = 1'b1;
                    n.nb_o = STAT_NOT_READY;
                    if (!s.mreq) begin
                        if (!cmd_ok) begin
                            n.mstat = STAT_READY | STAT_CMD_ERR;
                            n.mst = M_READY;
                        end else if (bus_err) begin
                            n.mstat = STAT_READY | STAT_BUS_ERR;
                            n.mst = M_READY;
                        end else begin
                            n.mreq = 1'b1;
                        end
                    end else if (mon_ack) begin
                        n.mreq = 1'b0;
                        n.mstat = mon_err ? (STAT_READY | STAT_BUS_ERR)
                            : STAT_READY;
                        if (!is_wr) begin
                            n.mdata = mon_rdata;
                        end
                        n.mst = M_READY;
                    end
                end
                M_READY: begin
                    n.nb_o = s.mstat;
                    if (s.fs_s2) begin
                        if (!is_wr && s.mstat == STAT_READY) begin
                            n.mcnt = 4'h0;
                            n.mst = M_OUT;
                        end else begin
                            n.nb_oe = 1'b0;
                            n.mst = M_CMD;
                        end
                    end
                end
                M_OUT: begin
                    if (ck_fall && s.mcnt == data_nibs) begin
                        n.nb_oe = 1'b0;
                        n.mst = M_CMD;
                    end else if (ck_fall) begin
                        n.nb_o = s.mdata[s.mcnt[2:0]*4 +: 4];
                        n.mcnt = s.mcnt + 4'h1;
                    end
                end
                default: n.mst = M_CMD;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hreadyout <= 1'b1;
            // pin samplers start at idle levels, no false edge
            s.ck_s1 <= 1'b1;
            s.ck_s2 <= 1'b1;
            s.ck_s3 <= 1'b1;
            s.fs_s1 <= 1'b1;
            s.fs_s2 <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0;
    assign debug_port_clock_out = s.ck_o;
    assign debug_port_clock_oe = s.ck_oe;
    assign frame_sync_n_out = s.fs_o;
    assign frame_sync_n_oe = s.fs_oe;
    assign debug_nibble_bus_out = s.nb_o;
    assign debug_nibble_bus_oe = s.nb_oe;
    assign mon_req = s.mreq;
    assign mon_write = is_wr;
    assign mon_size = size;
    assign mon_addr = s.maddr;
    assign mon_wdata = s.mdata;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic hdr_first;
    // header is first shown with the debug clock low
    assign hdr_first = trace_hdr && s.tst == T_SEND && !s.ck_o;

    sequence s_quiet4;
        (run_trace && !branch_taken)[*4];
    endsequence
    sequence s_hdr4;
        hdr_first && s.nb_o == {HEAD_PREFIX, LEN_4};
    endsequence
    sequence s_branch_quiet;
        run_trace && branch_taken ##1 (run_trace && !branch_taken)[*3];
    endsequence

    property p_half_clock;
        run_trace ##1 run_trace |-> s.ck_o != $past(s.ck_o);
    endproperty
    a_half_clock: assert property (p_half_clock)
        else $error("debug clock not toggling");
    property p_sync_valid;
        run_trace && !s.fs_o |-> s.tst == T_SEND && s.nb_oe;
    endproperty
    a_sync_valid: assert property (p_sync_valid)
        else $error("sync low outside address");
    property p_first_nibble;
        run_trace && $fell(s.fs_o) |-> s.nb_o == s.pend_addr[3:0];
    endproperty
    a_first_nibble: assert property (p_first_nibble)
        else $error("first nibble not lowest");
    property p_idle;
        run_trace && $past(run_trace) && s.tst == T_IDLE
            && $past(s.tst) == T_IDLE |-> s.fs_o && s.nb_o == NIB_IDLE;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle pattern missing");
    property p_header;
        hdr_first |-> s.tnib_left == (NIBS_4 << s.nb_o[1:0]);
    endproperty
    a_header: assert property (p_header)
        else $error("header length mismatch");
    property p_short;
        s_hdr4 ##0 s_quiet4 |-> !s.fs_o ##1 (s.fs_o && s.nb_o == NIB_IDLE);
    endproperty
    a_short: assert property (p_short)
        else $error("one nibble transfer wrong");
    property p_len32;
        hdr_first |-> (s.nb_o[1:0] == LEN_32)
            == (s.pend_addr[31:16] != s.cmp[31:16]);
    endproperty
    a_len32: assert property (p_len32)
        else $error("length code wrong");
    property p_cmp_start;
        $rose(s.rst_s2) |-> s.cmp == CMP_RESET;
    endproperty
    a_cmp_start: assert property (p_cmp_start)
        else $error("compare not cleared");
    property p_cmp_update;
        $changed(s.cmp) && $past(s.rst_s2) |->
            $past(s.tst) == T_SEND && $past(s.tnib_left) == 4'h0;
    endproperty
    a_cmp_update: assert property (p_cmp_update)
        else $error("compare updated early");
    property p_latency;
        s_branch_quiet |-> hdr_first or ##1 hdr_first;
    endproperty
    a_latency: assert property (p_latency)
        else $error("header latency wrong");
    property p_mode;
        $rose(s.rst_s2) |-> s.mode_mon == $past(s.mode_s2);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode not caught");
    property p_capture;
        s.mst == M_ADDR && $changed(s.maddr) |-> $past(take);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture without sync");
    property p_ready;
        s.rst_s2 && s.mreq && mon_ack && !mon_err |=> ##1 s.nb_o == STAT_READY;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready not returned");
    property p_cmd_err;
        s.rst_s2 && s.mst == M_EXEC && !s.mreq && !cmd_ok |=>
            !s.mreq ##1 s.nb_o == (STAT_READY | STAT_CMD_ERR);
    endproperty
    a_cmd_err: assert property (p_cmd_err)
        else $error("command error not flagged");
    property p_bus_err;
        s.rst_s2 && s.mreq && mon_ack && mon_err |=> ##1 s.nb_o[2];
    endproperty
    a_bus_err: assert property (p_bus_err)
        else $error("bus error not flagged");
    property p_port_reset;
        !s.rst_s2 |=> s.mst == M_CMD && s.tst == T_IDLE && !s.mreq;
    endproperty
    a_port_reset: assert property (p_port_reset)
        else $error("port reset incomplete");
endmodule
